// ==== verilog/acpu_core.v ====
// Overview of operation
// - Bit0 indirect, bits1-3 opcode, 12-bit address
// - Two extra cycles per indirect level
// - load_word loads accumulator, pc plus one
// - jump goes to address, accumulator kept
// - jump_save stores return, jumps plus one, clears
// - Add sets overflow, held until next setter
// - AND accumulator with memory operand
// - store_acc writes accumulator to memory
// - index_skip_zero increments, writes back, skips zero
// - shift_left by n, zero fill
// - rotate_left by n, top bit wraps
// - halt_op stops; run resumes, step advances
// - Skip on accumulator zero or nonzero
// - Skip when selected bit set, bit0 MSB
// - Skip when overflow clear
// - complement_acc negates accumulator
// - data_out_op drives bus, address, function, strobe
// - Broadcast, in_strobe, load word, release strobe
// - interrupt_return restores level state, four cycles
// - mask_ints holds interrupts until unmasked
// - unmask_ints lets held requests be taken
`include "acpu_defines.vh"

module acpu_core (
   // Clock and reset
   input wire mclk,
   input wire sys_rst,
   // Program memory
   output reg [14:0] mem_addr,
   output reg mem_rd,
   output reg mem_wr,
   output reg [15:0] mem_wdata,
   input wire [15:0] mem_rdata,
   // Direct I/O bus
   output reg [3:0] io_dev,
   output reg [3:0] io_func,
   output reg [15:0] io_data_out,
   output reg io_data_oe,
   input wire [15:0] io_data_in,
   output reg out_strobe,
   output reg in_strobe,
   // Operator controls and interrupt requests
   input wire run_btn,
   input wire step_btn,
   input wire [7:0] int_req,
   // Status
   output reg halted,
   output reg ints_masked
);

   // One-hot sequencer states
   localparam S_FETCH = 8'h01;
   localparam S_FWAIT = 8'h02;
   localparam S_DEC = 8'h04;
   localparam S_IWAIT = 8'h08;
   localparam S_IND = 8'h10;
   localparam S_OWAIT = 8'h20;
   localparam S_EXEC = 8'h40;
   localparam S_HALT = 8'h80;

   reg [7:0] state; // Sequencer state
   reg [14:0] pc; // Program counter
   reg [15:0] acc; // Accumulator
   reg ovf; // Overflow indicator
   reg [15:0] ir; // Current instruction
   reg [14:0] ea; // Effective address
   reg [15:0] opnd; // Latched operand or result
   reg [2:0] step; // Execution cycle index
   reg [2:0] ncyc; // Execution cycles of this instruction
   reg [2:0] wait_cnt; // in_strobe hold counter
   reg run_mode; // Free running versus single step
   reg [7:0] active; // Levels in service
   reg [7:0] pending; // Held interrupt requests

   // Per-level save areas, flip-flops indexed by level
   reg [14:0] sv_pc [0:7];
   reg [15:0] sv_acc [0:7];
   reg [7:0] sv_ovf;

   // Synchronisers for pins from outside
   reg [15:0] din_s1, din_s2;
   reg run_s1, run_s2, run_d;
   reg step_s1, step_s2, step_d;
   reg [7:0] irq_s1, irq_s2, irq_d;

   // Instruction fields, doc bit k sits at ir[15-k]
   wire [2:0] ir_op = ir[14:12];
   wire [4:0] ir_key = {ir[15], ir[11:8]};
   wire [3:0] ir_n = ir[3:0];
   wire [2:0] ir_lvl = ir[4:2];
   wire [2:0] dec_op = mem_rdata[14:12];

   // Derived results
   wire [31:0] rot_w = {acc, acc} << ir_n;
   wire [15:0] sum = acc + opnd;
   wire add_ovf = (acc[15] == opnd[15]) && (sum[15] != acc[15]);
   wire bit_sel = acc[4'hf - ir_n];
   wire [14:0] pc_inc = pc + 15'h0001;
   wire [14:0] pc_skip = pc + 15'h0002;

   // Button edges and interrupt request edges
   wire run_rise = run_s2 && !run_d;
   wire step_rise = step_s2 && !step_d;
   wire [7:0] irq_rise = irq_s2 & ~irq_d;

   // Lowest pending level wins; nesting is not supported
   reg [2:0] take_lvl;
   reg take_any;
   integer i;
   always @* begin
      take_lvl = 3'h0;
      take_any = 1'b0;
      for (i = 7; i >= 0; i = i - 1) begin
         if (pending[i]) begin
            take_lvl = i[2:0];
            take_any = 1'b1;
         end
      end
   end

   // Service only between instructions, unmasked, nothing active
   wire take_now = (state == S_FETCH) && take_any && !ints_masked &&
      (active == 8'h00);

   // Two-stage synchronisers; second stage feeds all logic
   always @(posedge mclk) begin
      if (sys_rst) begin
         din_s1 <= 16'h0000;
         din_s2 <= 16'h0000;
         run_s1 <= 1'b0;
         run_s2 <= 1'b0;
         run_d <= 1'b0;
         step_s1 <= 1'b0;
         step_s2 <= 1'b0;
         step_d <= 1'b0;
         irq_s1 <= 8'h00;
         irq_s2 <= 8'h00;
         irq_d <= 8'h00;
      end else begin
         din_s1 <= io_data_in;
         din_s2 <= din_s1;
         run_s1 <= run_btn;
         run_s2 <= run_s1;
         run_d <= run_s2;
         step_s1 <= step_btn;
         step_s2 <= step_s1;
         step_d <= step_s2;
         irq_s1 <= int_req;
         irq_s2 <= irq_s1;
         irq_d <= irq_s2;
      end
   end

   // Pending requests; a new edge wins over the clear on service
   always @(posedge mclk) begin
      if (sys_rst) begin
         pending <= 8'h00;
      end else if (take_now) begin
         pending <= (pending & ~(8'h01 << take_lvl)) | irq_rise;
      end else begin
         pending <= pending | irq_rise;
      end
   end

   // Save areas written on service; no reset needed for data
   always @(posedge mclk) begin
      if (take_now) begin
         sv_pc[take_lvl] <= pc;
         sv_acc[take_lvl] <= acc;
         sv_ovf[take_lvl] <= ovf;
      end
   end

   // Main sequencer
   always @(posedge mclk) begin
      if (sys_rst) begin
         state <= S_FETCH;
         pc <= `ACPU_RST_PC;
         acc <= 16'h0000;
         ovf <= 1'b0;
         ir <= 16'h0000;
         ea <= 15'h0000;
         opnd <= 16'h0000;
         step <= 3'h0;
         ncyc <= 3'h1;
         wait_cnt <= 3'h0;
         run_mode <= 1'b1;
         active <= 8'h00;
         mem_addr <= 15'h0000;
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         mem_wdata <= 16'h0000;
         io_dev <= 4'h0;
         io_func <= 4'h0;
         io_data_out <= 16'h0000;
         io_data_oe <= 1'b0;
         out_strobe <= 1'b0;
         in_strobe <= 1'b0;
         halted <= 1'b0;
         ints_masked <= 1'b0;
      end else begin
         case (state)
            // Issue instruction read, or divert to an interrupt vector
            S_FETCH: begin
               out_strobe <= 1'b0;
               io_data_oe <= 1'b0;
               halted <= 1'b0;
               mem_rd <= 1'b1;
               if (take_now) begin
                  active <= 8'h01 << take_lvl;
                  pc <= `ACPU_VEC_BASE + {12'h000, take_lvl};
                  mem_addr <= `ACPU_VEC_BASE + {12'h000, take_lvl};
               end else begin
                  mem_addr <= pc;
               end
               state <= S_FWAIT;
            end
            // Memory samples the read
            S_FWAIT: begin
               mem_rd <= 1'b0;
               state <= S_DEC;
            end
            // Instruction word arrives
            S_DEC: begin
               ir <= mem_rdata;
               step <= 3'h0;
               ea <= {3'h0, mem_rdata[11:0]};
               mem_addr <= {3'h0, mem_rdata[11:0]};
               if (dec_op == `ACPU_OP_GROUP) begin
                  ncyc <= (mem_rdata[15:8] == 8'h7f) ? `ACPU_CYC_IRET :
                     `ACPU_CYC_ONE;
                  state <= S_EXEC;
               end else begin
                  // Reads for indirection and for operand fetches
                  mem_rd <= mem_rdata[15] ||
                     (dec_op == `ACPU_OP_LOAD) || (dec_op == `ACPU_OP_ADD) ||
                     (dec_op == `ACPU_OP_AND) || (dec_op == `ACPU_OP_IDX);
                  case (dec_op)
                     `ACPU_OP_ADD: ncyc <= `ACPU_CYC_ADD;
                     `ACPU_OP_AND: ncyc <= `ACPU_CYC_AND;
                     `ACPU_OP_STORE: ncyc <= `ACPU_CYC_STORE;
                     `ACPU_OP_JSAVE: ncyc <= `ACPU_CYC_JSAVE;
                     `ACPU_OP_IDX: ncyc <= `ACPU_CYC_IDX;
                     default: ncyc <= `ACPU_CYC_ONE;
                  endcase
                  state <= mem_rdata[15] ? S_IWAIT : S_OWAIT;
               end
            end
            // Pointer read in flight
            S_IWAIT: begin
               mem_rd <= 1'b0;
               state <= S_IND;
            end
            // One pass per indirect level followed
            S_IND: begin
               ea <= mem_rdata[14:0];
               mem_addr <= mem_rdata[14:0];
               mem_rd <= mem_rdata[15] || (ir_op == `ACPU_OP_LOAD) ||
                  (ir_op == `ACPU_OP_ADD) || (ir_op == `ACPU_OP_AND) ||
                  (ir_op == `ACPU_OP_IDX);
               state <= mem_rdata[15] ? S_IWAIT : S_OWAIT;
            end
            // Operand read in flight
            S_OWAIT: begin
               mem_rd <= 1'b0;
               state <= S_EXEC;
            end
            // Execute; step counts the cycles of the instruction
            S_EXEC: begin
               step <= step + 3'h1;
               if (step == ncyc - 3'h1) begin
                  state <= run_mode ? S_FETCH : S_HALT;
                  pc <= pc_inc;
               end
               if (ir_op != `ACPU_OP_GROUP) begin
                  case (ir_op)
                     `ACPU_OP_LOAD: begin
                        acc <= mem_rdata;
                     end
                     `ACPU_OP_JUMP: begin
                        pc <= ea;
                     end
                     `ACPU_OP_ADD: begin
                        if (step == 3'h0) begin
                           opnd <= mem_rdata;
                        end else begin
                           acc <= sum;
                           ovf <= add_ovf;
                        end
                     end
                     `ACPU_OP_AND: begin
                        if (step == 3'h0) begin
                           opnd <= mem_rdata;
                        end else begin
                           acc <= acc & opnd;
                        end
                     end
                     `ACPU_OP_STORE: begin
                        mem_wdata <= acc;
                        mem_wr <= (step == 3'h0);
                     end
                     `ACPU_OP_JSAVE: begin
                        // Return address written, then jump past it
                        mem_wdata <= {1'b0, pc_inc};
                        mem_wr <= (step == 3'h0);
                        if (step == 3'h2) begin
                           pc <= ea + 15'h0001;
                           acc <= 16'h0000;
                        end
                     end
                     default: begin
                        // Index: read, increment, write back, test
                        if (step == 3'h0) begin
                           opnd <= mem_rdata + 16'h0001;
                           ovf <= (mem_rdata == 16'hffff);
                        end
                        mem_wdata <= opnd;
                        mem_wr <= (step == 3'h1);
                        if (step == 3'h2) begin
                           acc <= opnd;
                           if (opnd == 16'h0000) begin
                              pc <= pc_skip;
                           end
                        end
                     end
                  endcase
               end else begin
                  case (ir_key)
                     `ACPU_K_SHL: acc <= acc << ir_n;
                     `ACPU_K_ROL: acc <= rot_w[31:16];
                     `ACPU_K_HALT: state <= S_HALT;
                     `ACPU_K_SKZ: begin
                        if (acc == 16'h0000) begin
                           pc <= pc_skip;
                        end
                     end
                     `ACPU_K_SKNZ: begin
                        if (acc != 16'h0000) begin
                           pc <= pc_skip;
                        end
                     end
                     `ACPU_K_SKBIT: begin
                        if (bit_sel) begin
                           pc <= pc_skip;
                        end
                     end
                     `ACPU_K_SKNOV: begin
                        if (!ovf) begin
                           pc <= pc_skip;
                        end
                     end
                     `ACPU_K_CMPL: acc <= ~acc + 16'h0001;
                     `ACPU_K_DOUT: begin
                        // Word, address and function move together
                        io_data_out <= acc;
                        io_data_oe <= 1'b1;
                        io_dev <= ir[7:4];
                        io_func <= ir[3:0];
                        out_strobe <= 1'b1;
                     end
                     `ACPU_K_DIN: begin
                        // Hold the step until the synced word settles
                        io_dev <= ir[7:4];
                        io_func <= ir[3:0];
                        if (!in_strobe) begin
                           in_strobe <= 1'b1;
                           wait_cnt <= 3'h0;
                           step <= step;
                           state <= S_EXEC;
                           pc <= pc;
                        end else if (wait_cnt != `ACPU_IN_WAIT) begin
                           wait_cnt <= wait_cnt + 3'h1;
                           step <= step;
                           state <= S_EXEC;
                           pc <= pc;
                        end else begin
                           acc <= din_s2;
                           in_strobe <= 1'b0;
                        end
                     end
                     `ACPU_K_IRET: begin
                        if (step == 3'h3) begin
                           pc <= sv_pc[ir_lvl];
                           acc <= sv_acc[ir_lvl];
                           ovf <= sv_ovf[ir_lvl];
                           active[ir_lvl] <= 1'b0;
                        end
                     end
                     `ACPU_K_MASK: ints_masked <= 1'b1;
                     `ACPU_K_UNMASK: ints_masked <= 1'b0;
                     default: begin
                        // Unknown group code acts as a no-op
                     end
                  endcase
               end
            end
            // Stopped; run resumes, step runs one instruction
            S_HALT: begin
               halted <= 1'b1;
               out_strobe <= 1'b0;
               io_data_oe <= 1'b0;
               mem_wr <= 1'b0;
               if (run_rise) begin
                  run_mode <= 1'b1;
                  state <= S_FETCH;
               end else if (step_rise) begin
                  run_mode <= 1'b0;
                  state <= S_FETCH;
               end
            end
            default: begin
               state <= S_FETCH;
            end
         endcase
      end
   end

endmodule

// ==== verilog/acpu_defines.vh ====
`ifndef ACPU_DEFINES_VH
`define ACPU_DEFINES_VH

// Word and address widths, interrupt level count
`define ACPU_WORD_W 16
`define ACPU_ADDR_W 15
`define ACPU_LEVELS 8

// Memory-reference operation codes
`define ACPU_OP_LOAD 3'h0
`define ACPU_OP_JUMP 3'h1
`define ACPU_OP_ADD 3'h2
`define ACPU_OP_JSAVE 3'h3
`define ACPU_OP_AND 3'h4
`define ACPU_OP_STORE 3'h5
`define ACPU_OP_IDX 3'h6
`define ACPU_OP_GROUP 3'h7

// Group keys: {first word bit, four sub-op bits}
`define ACPU_K_SHL 5'h00
`define ACPU_K_ROL 5'h10
`define ACPU_K_HALT 5'h09
`define ACPU_K_SKZ 5'h04
`define ACPU_K_SKNZ 5'h14
`define ACPU_K_SKBIT 5'h15
`define ACPU_K_SKNOV 5'h02
`define ACPU_K_CMPL 5'h03
`define ACPU_K_DOUT 5'h01
`define ACPU_K_DIN 5'h0c
`define ACPU_K_IRET 5'h0f
`define ACPU_K_MASK 5'h1e
`define ACPU_K_UNMASK 5'h0e

// Execution cycle counts
`define ACPU_CYC_ONE 3'h1
`define ACPU_CYC_ADD 3'h2
`define ACPU_CYC_AND 3'h2
`define ACPU_CYC_STORE 3'h2
`define ACPU_CYC_JSAVE 3'h3
`define ACPU_CYC_IDX 3'h3
`define ACPU_CYC_IRET 3'h4

// Clocks in_strobe is held, after its first, before the bus word is taken
`define ACPU_IN_WAIT 3'h4

// Start address and interrupt vector base
`define ACPU_RST_PC 15'h0000
`define ACPU_VEC_BASE 15'h0010

`endif

// ==== dv/acpu_io_model.sv ====
// Peripheral on the direct I/O bus: one device address, one input function
module acpu_io_model #(
   parameter logic [3:0] DEV = 4'h3,
   parameter logic [3:0] FUNC = 4'h9,
   parameter logic [15:0] REPLY = 16'h3c5a
) (
   // Clock
   input wire logic mclk,
   // Bus from the processor
   input wire logic [3:0] io_dev,
   input wire logic [3:0] io_func,
   input wire logic [15:0] io_data_out,
   input wire logic io_data_oe,
   input wire logic out_strobe,
   input wire logic in_strobe,
   // Bus towards the processor
   output logic [15:0] io_data_in,
   // Last captured output word and function, capture count
   output logic [15:0] cap_word,
   output logic [3:0] cap_func,
   output logic [7:0] cap_cnt
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] noise = 16'h0f0f; // Undriven bus, never a stale value
   logic [15:0] bus; // Word actually present on the shared bus
   initial cap_cnt = 8'h00;
   // Released bus changes every cycle so a late sample is seen as wrong
   always @(posedge mclk) noise <= noise + 16'h1357;
   assign bus = io_data_oe ? io_data_out : noise;
   // Drive only while addressed and strobed
   assign io_data_in = (in_strobe && io_dev == DEV && io_func == FUNC) ?
      REPLY : noise;
   // Capture the bus word on the output strobe
   always @(posedge mclk) begin
      if (out_strobe && io_dev == DEV) begin
         cap_word <= bus;
         cap_func <= io_func;
         cap_cnt <= cap_cnt + 8'h01;
      end
   end
endmodule

// ==== dv/acpu_core_asserts.sv ====
// Port-level checks on the core
module acpu_core_asserts (
   // Clock and reset
   input logic mclk,
   input logic sys_rst,
   // Memory, I/O and status outputs watched
   input logic mem_rd,
   input logic mem_wr,
   input logic [3:0] io_dev,
   input logic [3:0] io_func,
   input logic io_data_oe,
   input logic out_strobe,
   input logic in_strobe,
   input logic halted
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_dout_pulse: assert property (out_strobe |-> io_data_oe ##1
      (!out_strobe && !io_data_oe)) else $error("output strobe not a pulse");
   a_oe_with_strobe: assert property (io_data_oe |-> out_strobe
      && !in_strobe) else $error("bus driven outside output strobe");
   a_din_length: assert property ($rose(in_strobe) |->
      in_strobe[*5] ##1 !in_strobe) else $error("input strobe length wrong");
   a_din_addr_hold: assert property (in_strobe && $past(in_strobe)
      |-> $stable(io_dev) && $stable(io_func))
      else $error("address moved under input strobe");
   a_io_addr_hold: assert property (!$rose(out_strobe) &&
      !$rose(in_strobe) |-> $stable(io_dev) && $stable(io_func))
      else $error("device address changed without a strobe");
   a_halt_quiet: assert property (halted && $past(halted) |->
      !mem_wr && !out_strobe && !in_strobe) else $error("activity while halted");
   a_wr_no_rd: assert property (mem_wr |-> !mem_rd && !out_strobe)
      else $error("write overlaps another access");
   a_wr_single: assert property (mem_wr |=> !mem_wr)
      else $error("write strobe longer than one cycle");
endmodule

bind acpu_core acpu_core_asserts u_chk (.mclk(mclk), .sys_rst(sys_rst),
   .mem_rd(mem_rd), .mem_wr(mem_wr), .io_dev(io_dev), .io_func(io_func),
   .io_data_oe(io_data_oe), .out_strobe(out_strobe), .in_strobe(in_strobe),
   .halted(halted));

// ==== dv/accumulator_cpu_instruction_execute_test.sv ====
`include "acpu_defines.vh"
module accumulator_cpu_instruction_execute_test;
   timeunit 1ns;
   timeprecision 100ps;
   // Design inputs
   logic mclk, sys_rst, run_btn, step_btn;
   logic [7:0] int_req;
   logic [15:0] mem_rdata, io_data_in;
   // Design and I/O model outputs
   logic [14:0] mem_addr;
   logic mem_rd, mem_wr, io_data_oe, out_strobe, in_strobe;
   logic halted, ints_masked;
   logic [15:0] mem_wdata, io_data_out, cap_word;
   logic [3:0] io_dev, io_func, cap_func;
   logic [7:0] cap_cnt;
   logic [15:0] mem [0:4095]; // Program memory, low 4K words
   int miscompares, checks, waited;

   acpu_core u_dut (.mclk(mclk), .sys_rst(sys_rst), .mem_addr(mem_addr),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .io_dev(io_dev), .io_func(io_func),
      .io_data_out(io_data_out), .io_data_oe(io_data_oe),
      .io_data_in(io_data_in), .out_strobe(out_strobe),
      .in_strobe(in_strobe), .run_btn(run_btn), .step_btn(step_btn),
      .int_req(int_req), .halted(halted), .ints_masked(ints_masked));
   acpu_io_model u_io (.mclk(mclk), .io_dev(io_dev), .io_func(io_func),
      .io_data_out(io_data_out), .io_data_oe(io_data_oe),
      .out_strobe(out_strobe), .in_strobe(in_strobe),
      .io_data_in(io_data_in), .cap_word(cap_word), .cap_func(cap_func),
      .cap_cnt(cap_cnt));

   // Clock, 5 ns period
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // Memory answers one clock after the read and holds the word
   always @(posedge mclk) begin
      if (mem_rd) mem_rdata <= mem[mem_addr[11:0]];
      if (mem_wr) mem[mem_addr[11:0]] <= mem_wdata;
   end

   function automatic logic [15:0] mr(input logic i, input logic [2:0] op,
      input logic [11:0] a);
      return {i, op, a};
   endfunction
   // Group word from its five-bit key and low byte
   function automatic logic [15:0] grp(input logic [4:0] k,
      input logic [7:0] lo);
      return {k[4], 3'h7, k[3:0], lo};
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input string name, input logic [15:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Bounded wait for a level on halted; a hang ends the run
   task automatic wait_halt(input logic lvl);
      int i;
      for (i = 0; i < 3000 && halted !== lvl; i++) tick(1);
      waited = i;
      if (halted !== lvl) begin
         miscompares++;
         $display("ERROR halted expected %b seen %b", lvl, halted);
         summarize();
      end
   endtask
   // Fill memory with a marker; reset held 8 cycles
   task automatic clear_mem();
      sys_rst = 1'b1;
      for (int i = 0; i < 4096; i++) mem[i] = 16'h5555;
   endtask
   task automatic run_prog();
      tick(8);
      sys_rst = 1'b0;
      wait_halt(1'b1);
   endtask

   // Two-level indirect load, store, jump over a store
   task automatic t_mem_ref();
      clear_mem();
      mem[0] = mr(1, `ACPU_OP_LOAD, 12'h020);
      mem[12'h020] = 16'h8022;
      mem[12'h022] = 16'h0021;
      mem[12'h021] = 16'h1234;
      mem[1] = mr(0, `ACPU_OP_STORE, 12'h040);
      mem[2] = mr(0, `ACPU_OP_JUMP, 12'h005);
      mem[3] = mr(0, `ACPU_OP_STORE, 12'h041);
      mem[5] = grp(`ACPU_K_HALT, 8'h00);
      run_prog();
      chk("run clocks", waited[15:0], 16'h0019);
      chk("indirect load", mem[12'h040], 16'h1234);
      chk("jump over", mem[12'h041], 16'h5555);
      $display("test mem_ref done");
   endtask

   // Arithmetic, logic, shift, rotate and skips
   task automatic t_alu();
      clear_mem();
      mem[12'h030] = 16'h8000;
      mem[12'h031] = 16'h8001;
      mem[12'h032] = 16'hf0f0;
      mem[12'h033] = 16'h0001;
      mem[0] = mr(0, `ACPU_OP_LOAD, 12'h030);
      mem[1] = mr(0, `ACPU_OP_ADD, 12'h030);
      mem[2] = grp(`ACPU_K_SKNOV, 8'h00);
      mem[3] = mr(0, `ACPU_OP_STORE, 12'h040);
      mem[4] = mr(0, `ACPU_OP_LOAD, 12'h031);
      mem[5] = grp(`ACPU_K_CMPL, 8'h00);
      mem[6] = mr(0, `ACPU_OP_AND, 12'h032);
      mem[7] = mr(0, `ACPU_OP_STORE, 12'h041);
      mem[8] = grp(`ACPU_K_SHL, 8'h04);
      mem[9] = grp(`ACPU_K_ROL, 8'h06);
      mem[10] = mr(0, `ACPU_OP_STORE, 12'h042);
      mem[11] = grp(`ACPU_K_SKBIT, 8'h00);
      mem[12] = mr(0, `ACPU_OP_STORE, 12'h043);
      mem[13] = grp(`ACPU_K_SKBIT, 8'h0d);
      mem[14] = mr(0, `ACPU_OP_STORE, 12'h044);
      mem[15] = grp(`ACPU_K_SKZ, 8'h00);
      mem[16] = grp(`ACPU_K_SKNZ, 8'h00);
      mem[17] = mr(0, `ACPU_OP_STORE, 12'h045);
      mem[18] = mr(0, `ACPU_OP_ADD, 12'h033);
      mem[19] = grp(`ACPU_K_SKNOV, 8'h00);
      mem[20] = mr(0, `ACPU_OP_STORE, 12'h046);
      mem[21] = grp(`ACPU_K_HALT, 8'h00);
      run_prog();
      chk("add overflow", mem[12'h040], 16'h0000);
      chk("negate and", mem[12'h041], 16'h70f0);
      chk("shift rotate", mem[12'h042], 16'hc003);
      chk("bit 0 skip", mem[12'h043], 16'h5555);
      chk("bit 13 no skip", mem[12'h044], 16'hc003);
      chk("zero nonzero", mem[12'h045], 16'h5555);
      chk("no overflow skip", mem[12'h046], 16'h5555);
      $display("test alu done");
   endtask

   // Index with wrap, zero skip, jump and save
   task automatic t_index();
      clear_mem();
      mem[12'h031] = 16'hffff;
      mem[12'h032] = 16'h1234;
      mem[12'h033] = 16'h0010;
      mem[0] = mr(0, `ACPU_OP_IDX, 12'h031);
      mem[1] = mr(0, `ACPU_OP_STORE, 12'h040);
      mem[2] = grp(`ACPU_K_SKZ, 8'h00);
      mem[3] = mr(0, `ACPU_OP_STORE, 12'h041);
      mem[4] = mr(0, `ACPU_OP_LOAD, 12'h032);
      mem[5] = mr(0, `ACPU_OP_JSAVE, 12'h050);
      mem[12'h051] = mr(0, `ACPU_OP_STORE, 12'h042);
      mem[12'h052] = mr(0, `ACPU_OP_IDX, 12'h033);
      mem[12'h053] = mr(0, `ACPU_OP_STORE, 12'h043);
      mem[12'h054] = grp(`ACPU_K_HALT, 8'h00);
      run_prog();
      chk("index wrap", mem[12'h031], 16'h0000);
      chk("index skip", mem[12'h040], 16'h5555);
      chk("zero skip", mem[12'h041], 16'h5555);
      chk("return addr", mem[12'h050], 16'h0006);
      chk("acc cleared", mem[12'h042], 16'h0000);
      chk("index plain", mem[12'h033], 16'h0011);
      chk("index acc", mem[12'h043], 16'h0011);
      $display("test index done");
   endtask

   // Output then input on the direct I/O bus
   task automatic t_io();
      clear_mem();
      mem[12'h030] = 16'ha5c3;
      mem[0] = mr(0, `ACPU_OP_LOAD, 12'h030);
      mem[1] = grp(`ACPU_K_DOUT, 8'h39);
      mem[2] = grp(`ACPU_K_DIN, 8'h39);
      mem[3] = mr(0, `ACPU_OP_STORE, 12'h040);
      mem[4] = grp(`ACPU_K_HALT, 8'h00);
      run_prog();
      chk("out word", cap_word, 16'ha5c3);
      chk("out func", {12'h000, cap_func}, 16'h0009);
      chk("out count", {8'h00, cap_cnt}, 16'h0001);
      chk("in word", mem[12'h040], 16'h3c5a);
      chk("device", {12'h000, io_dev}, 16'h0003);
      $display("test io done");
   endtask

   // Masked request held through halt, run, service, return, step
   task automatic t_irq();
      clear_mem();
      mem[12'h033] = 16'h1111;
      mem[12'h032] = 16'hbeef;
      mem[0] = mr(0, `ACPU_OP_LOAD, 12'h033);
      mem[1] = grp(`ACPU_K_MASK, 8'h00);
      mem[2] = grp(`ACPU_K_HALT, 8'h00);
      mem[3] = grp(`ACPU_K_UNMASK, 8'h00);
      mem[4] = mr(0, `ACPU_OP_STORE, 12'h040);
      mem[5] = grp(`ACPU_K_HALT, 8'h00);
      mem[6] = mr(0, `ACPU_OP_STORE, 12'h042);
      mem[7] = grp(`ACPU_K_HALT, 8'h00);
      mem[12'h011] = mr(0, `ACPU_OP_STORE, 12'h041);
      mem[12'h012] = mr(0, `ACPU_OP_LOAD, 12'h032);
      mem[12'h013] = grp(`ACPU_K_IRET, 8'h04);
      run_prog();
      chk("masked", {15'h0000, ints_masked}, 16'h0001);
      int_req = 8'h02;
      tick(10);
      chk("held while masked", mem[12'h041], 16'h5555);
      chk("stays halted", {15'h0000, halted}, 16'h0001);
      run_btn = 1'b1;
      tick(1);
      run_btn = 1'b0;
      wait_halt(1'b0);
      wait_halt(1'b1);
      chk("service entry", mem[12'h041], 16'h1111);
      chk("restored acc", mem[12'h040], 16'h1111);
      chk("unmasked", {15'h0000, ints_masked}, 16'h0000);
      step_btn = 1'b1;
      tick(1);
      step_btn = 1'b0;
      wait_halt(1'b0);
      wait_halt(1'b1);
      chk("single step", mem[12'h042], 16'h1111);
      int_req = 8'h00;
      $display("test irq done");
   endtask

   initial begin
      sys_rst = 1'b1;
      run_btn = 1'b0;
      step_btn = 1'b0;
      int_req = 8'h00;
      mem_rdata = 16'h0000;
      miscompares = 0;
      checks = 0;
      t_mem_ref();
      t_alu();
      t_index();
      t_io();
      t_irq();
      summarize();
   end
endmodule
